// *** hdl/data_memory_access.v ***
// Purpose: Internal RAM decode, expanded RAM and external data moves
// Assumes: Core issues one access at a time; clock is the oscillator
// Notes: RAM arrays have no reset and start undefined
// Operation
// - Lower 128 bytes at 00h-7Fh reached directly and indirectly.
// - Lowest 32 bytes form four banks of eight working registers.
// - Two bank-select bits place the active bank at 00h, 08h, 10h or 18h.
// - Bytes 20h-2Fh give bit addresses 00h-7Fh for single-bit access.
// - Upper 128 bytes at 80h-FFh reached only indirectly.
// - Direct accesses at 80h-FFh go to special registers.
// - 2048 bytes expanded RAM at 0000h-07FFh via external moves only.
// - Offchip select bit 0 uses expanded RAM, 1 uses external bus.
// - Three-bit size field limits expanded RAM, 2048 bytes after reset.
// - Size codes 256,512,768,1024,1792,2048; reset 101; 110/111 reserved.
// - No RAM is initialised; contents undefined until written.
// - External access: high address on port two, low multiplexed on port zero.
// - Latch strobe pulses while low address is valid.
// - Active-low read or write strobe, one per access.
// - Each external cycle lasts six CPU clock periods, eighteen when stretched.
// - Stretch bit widens strobes from 3 to 15 CPU periods.
// - Eight-bit indirect move puts port two latch on high lines.
// - Two data pointers share addresses 83h and 84h, chosen by select bit.
// - Select bit 0 of aux control picks second pointer when set.
// - Increment of aux control toggles the pointer select bit.
// - Bit 2 of aux control reads zero always.
// - CPU uses 12 oscillator periods per machine cycle, 6 in double speed.
`timescale 1ns/1ns
`include "data_memory_map.vh"

module data_memory_access
#(
  parameter XMEM_DEPTH = `XMEM_DEPTH
)
(
  // Clock and reset
  input wire clock,
  input wire srst,
  // Speed and bank selection from the core; CPU and machine ticks back to it
  input wire double_speed_bit,
  input wire bank_select_low,
  input wire bank_select_high,
  output reg cpu_tick_r,
  output reg machine_tick_r,
  // Internal access port
  input wire acc_req,
  input wire acc_we,
  input wire [1:0] acc_mode,
  input wire [7:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire aux_control_inc,
  output reg acc_ack_r,
  output reg [7:0] acc_rdata_r,
  // Forwarded special register accesses
  output wire sfr_req,
  output wire sfr_we,
  output wire sfr_bit,
  output wire [7:0] sfr_addr,
  output wire [2:0] sfr_bit_pos,
  output wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  // Data pointer operations
  input wire ptr_load,
  input wire [15:0] ptr_load_value,
  input wire ptr_inc,
  output wire [15:0] data_pointer,
  // External move port
  input wire xmv_req,
  input wire xmv_we,
  input wire xmv_ri,
  input wire [7:0] xmv_ri_addr,
  input wire [7:0] xmv_wdata,
  input wire [7:0] port_two_latch,
  output wire xmv_busy,
  output reg xmv_done_r,
  output reg [7:0] xmv_rdata_r,
  // Configuration state
  output reg [7:0] aux_config_reg_r,
  output reg [7:0] aux_control_reg_r,
  // External bus pins
  output wire [7:0] addr_high_lines,
  output wire [7:0] addr_data_low_lines_out,
  output wire addr_data_low_lines_oe,
  input wire [7:0] addr_data_low_lines_in,
  output wire ale,
  output wire rd_n,
  output wire wr_n
);

  ////////////////////////////////////////////////////////////////
  // CPU clock and machine cycle

  reg osc_div_r;
  reg [2:0] mach_cnt_r;
  wire cpu_tick_nxt;

  assign cpu_tick_nxt = double_speed_bit ? 1'b1 : osc_div_r;

  always @(posedge clock)
  begin
    if (srst)
    begin
      osc_div_r <= 1'b0;
      mach_cnt_r <= 3'h0;
      cpu_tick_r <= 1'b0;
      machine_tick_r <= 1'b0;
    end
    else
    begin
      osc_div_r <= ~osc_div_r;
      cpu_tick_r <= cpu_tick_nxt;
      machine_tick_r <= 1'b0;
      if (cpu_tick_nxt)
      begin
        if (mach_cnt_r == 3'd`CPU_PER_MACHINE - 3'd1)
        begin
          mach_cnt_r <= 3'h0;
          machine_tick_r <= 1'b1;
        end
        else
        begin
          mach_cnt_r <= mach_cnt_r + 3'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Internal address decode

  reg [7:0] iram_r [0:255];
  reg [7:0] iaddr;
  reg to_sfr;
  reg is_bit;
  reg bit_val;
  wire local_sfr;
  wire [1:0] bank;

  assign bank = {bank_select_high, bank_select_low};

  always @*
  begin
    iaddr = acc_addr;
    to_sfr = 1'b0;
    is_bit = 1'b0;
    case (acc_mode)
      `MODE_DIRECT:
      begin
        to_sfr = acc_addr[7];
      end
      `MODE_INDIRECT:
      begin
        iaddr = acc_addr;
      end
      `MODE_REGISTER:
      begin
        iaddr = {3'h0, bank, acc_addr[2:0]};
      end
      `MODE_BIT:
      begin
        is_bit = 1'b1;
        to_sfr = acc_addr[7];
        iaddr = {4'h0, `BIT_AREA_BASE} << 4 | {4'h0, acc_addr[6:3]};
      end
      default:
      begin
        iaddr = acc_addr;
      end
    endcase
    bit_val = iram_r[iaddr][acc_addr[2:0]];
  end

  // Direct hits on the pointer and aux registers stay here
  assign local_sfr = to_sfr && !is_bit && (acc_addr == `ADDR_POINTER_LOW ||
    acc_addr == `ADDR_POINTER_HIGH || acc_addr == `ADDR_AUX_CONFIG ||
    acc_addr == `ADDR_AUX_CONTROL);

  assign sfr_req = acc_req && to_sfr && !local_sfr;
  assign sfr_we = acc_we;
  assign sfr_bit = is_bit;
  assign sfr_addr = is_bit ? {acc_addr[7:3], 3'h0} : acc_addr;
  assign sfr_bit_pos = acc_addr[2:0];
  assign sfr_wdata = acc_wdata;

  ////////////////////////////////////////////////////////////////
  // Data pointers and aux registers

  reg [15:0] ptr_r [0:1];
  wire sel;
  wire [7:0] aux_control_inc_val;

  assign sel = aux_control_reg_r[`CTL_PTR_SEL_BIT];
  assign data_pointer = ptr_r[sel];
  // Carry out of bits 1:0 dies at the stuck bit
  assign aux_control_inc_val = {aux_control_reg_r[7:3], 1'b0, aux_control_reg_r[1:0] + 2'd1};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_ptr
      wire hit;
      assign hit = g ? sel : !sel;
      always @(posedge clock)
      begin
        if (srst)
        begin
          ptr_r[g] <= 16'h0000;
        end
        else if (hit && ptr_load)
        begin
          ptr_r[g] <= ptr_load_value;
        end
        else if (hit && ptr_inc)
        begin
          ptr_r[g] <= ptr_r[g] + 16'h0001;
        end
        else if (hit && acc_req && acc_we && local_sfr && acc_addr == `ADDR_POINTER_LOW)
        begin
          ptr_r[g] <= {ptr_r[g][15:8], acc_wdata};
        end
        else if (hit && acc_req && acc_we && local_sfr && acc_addr == `ADDR_POINTER_HIGH)
        begin
          ptr_r[g] <= {acc_wdata, ptr_r[g][7:0]};
        end
      end
    end
  endgenerate

  always @(posedge clock)
  begin
    if (srst)
    begin
      aux_config_reg_r <= `AUX_CONFIG_RST;
      aux_control_reg_r <= `AUX_CONTROL_RST;
    end
    else
    begin
      if (acc_req && acc_we && local_sfr && acc_addr == `ADDR_AUX_CONFIG)
      begin
        aux_config_reg_r <= acc_wdata & `AUX_CONFIG_MASK;
      end
      if (aux_control_inc)
      begin
        aux_control_reg_r <= aux_control_inc_val;
      end
      else if (acc_req && acc_we && local_sfr && acc_addr == `ADDR_AUX_CONTROL)
      begin
        aux_control_reg_r <= acc_wdata & `AUX_CONTROL_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Internal access answer

  reg [7:0] local_rdata;

  always @*
  begin
    case (acc_addr)
      `ADDR_POINTER_LOW: local_rdata = data_pointer[7:0];
      `ADDR_POINTER_HIGH: local_rdata = data_pointer[15:8];
      `ADDR_AUX_CONFIG: local_rdata = aux_config_reg_r;
      `ADDR_AUX_CONTROL: local_rdata = aux_control_reg_r;
      default: local_rdata = 8'h00;
    endcase
  end

  always @(posedge clock)
  begin
    if (acc_req && acc_we && !to_sfr)
    begin
      if (is_bit)
      begin
        iram_r[iaddr][acc_addr[2:0]] <= acc_wdata[0];
      end
      else
      begin
        iram_r[iaddr] <= acc_wdata;
      end
    end
  end

  always @(posedge clock)
  begin
    if (srst)
    begin
      acc_ack_r <= 1'b0;
      acc_rdata_r <= 8'h00;
    end
    else
    begin
      acc_ack_r <= acc_req;
      if (acc_req && !acc_we)
      begin
        if (local_sfr)
        begin
          acc_rdata_r <= local_rdata;
        end
        else if (to_sfr)
        begin
          acc_rdata_r <= is_bit ? {7'h00, sfr_rdata[acc_addr[2:0]]} : sfr_rdata;
        end
        else if (is_bit)
        begin
          acc_rdata_r <= {7'h00, bit_val};
        end
        else
        begin
          acc_rdata_r <= iram_r[iaddr];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // External moves: expanded RAM or bus

  reg [7:0] xmem_r [0:XMEM_DEPTH-1];
  reg [11:0] xlimit;
  wire [15:0] xaddr;
  wire onchip;
  wire bus_busy;
  wire bus_done;
  wire [7:0] bus_rdata;
  wire bus_start;

  always @*
  begin
    case (aux_config_reg_r[`CFG_SIZE_MSB:`CFG_SIZE_LSB])
      `XSIZE_256: xlimit = 12'd256;
      `XSIZE_512: xlimit = 12'd512;
      `XSIZE_768: xlimit = 12'd768;
      `XSIZE_1024: xlimit = 12'd1024;
      `XSIZE_1792: xlimit = 12'd1792;
      // Reserved codes behave as the full size
      default: xlimit = 12'd2048;
    endcase
  end

  assign xaddr = xmv_ri ? {port_two_latch, xmv_ri_addr} : data_pointer;
  assign onchip = !aux_config_reg_r[`CFG_OFFCHIP_BIT] && xaddr < {4'h0, xlimit};
  assign bus_start = xmv_req && !onchip && !bus_busy;
  assign xmv_busy = bus_busy;

  always @(posedge clock)
  begin
    if (xmv_req && onchip && xmv_we && !bus_busy)
    begin
      xmem_r[xaddr[10:0]] <= xmv_wdata;
    end
  end

  always @(posedge clock)
  begin
    if (srst)
    begin
      xmv_done_r <= 1'b0;
      xmv_rdata_r <= 8'h00;
    end
    else
    begin
      xmv_done_r <= 1'b0;
      if (xmv_req && onchip && !bus_busy)
      begin
        xmv_done_r <= 1'b1;
        xmv_rdata_r <= xmv_we ? xmv_rdata_r : xmem_r[xaddr[10:0]];
      end
      else if (bus_done)
      begin
        xmv_done_r <= 1'b1;
        xmv_rdata_r <= bus_rdata;
      end
    end
  end

  ext_bus_cycle u_bus
  (
    .clock(clock),
    .srst(srst),
    .cpu_tick(cpu_tick_nxt),
    .start(bus_start),
    .write(xmv_we),
    .stretch(aux_config_reg_r[`CFG_STRETCH_BIT]),
    .addr(xaddr),
    .wdata(xmv_wdata),
    .busy(bus_busy),
    .done_r(bus_done),
    .rdata_r(bus_rdata),
    .addr_high_lines_r(addr_high_lines),
    .addr_data_low_out_r(addr_data_low_lines_out),
    .addr_data_low_oe_r(addr_data_low_lines_oe),
    .addr_data_low_in(addr_data_low_lines_in),
    .ale_r(ale),
    .rd_n_r(rd_n),
    .wr_n_r(wr_n)
  );

endmodule

// *** hdl/data_memory_map.vh ***
// Purpose: Constants for the data-memory access unit
// Assumes: Oscillator-rate clock, byte-wide internal spaces
// Notes: Included by both design files
`ifndef DATA_MEMORY_MAP_VH
`define DATA_MEMORY_MAP_VH

// Access modes from the core
`define MODE_DIRECT 2'h0
`define MODE_INDIRECT 2'h1
`define MODE_REGISTER 2'h2
`define MODE_BIT 2'h3

// Internal space boundaries
`define LOWER_TOP 8'h7F
`define UPPER_BASE 8'h80
`define BIT_AREA_BASE 4'h2

// Locally held special registers
`define ADDR_POINTER_LOW 8'h83
`define ADDR_POINTER_HIGH 8'h84
`define ADDR_AUX_CONFIG 8'h8E
`define ADDR_AUX_CONTROL 8'hA2

// Aux config fields and reset
`define CFG_OFFCHIP_BIT 1
`define CFG_SIZE_LSB 2
`define CFG_SIZE_MSB 4
`define CFG_STRETCH_BIT 5
`define AUX_CONFIG_RST 8'h14
`define AUX_CONFIG_MASK 8'h3F

// Aux control fields and reset
`define CTL_PTR_SEL_BIT 0
`define CTL_ZERO_BIT 2
`define AUX_CONTROL_RST 8'h00
`define AUX_CONTROL_MASK 8'hFB

// Expanded RAM size codes, in bytes
`define XSIZE_256 3'h0
`define XSIZE_512 3'h1
`define XSIZE_768 3'h2
`define XSIZE_1024 3'h3
`define XSIZE_1792 3'h4
`define XSIZE_2048 3'h5
`define XMEM_DEPTH 2048

// Timing in oscillator and CPU clock periods
`define OSC_PER_CPU_STD 2
`define OSC_PER_CPU_X2 1
`define CPU_PER_MACHINE 6
`define EXT_CYCLE_PERIODS 6
`define STROBE_NORMAL 3
`define STROBE_STRETCH 15
`define ALE_PERIODS 1
`define ADDR_HOLD_PERIODS 1

`endif

// *** hdl/ext_bus_cycle.v ***
// Purpose: One external data cycle on the multiplexed bus
// Assumes: cpu_tick marks each CPU clock period
// Notes: Phases: latch, hold, strobe, tail
`timescale 1ns/1ns
`include "data_memory_map.vh"

module ext_bus_cycle
(
  // Clock and reset
  input wire clock,
  input wire srst,
  input wire cpu_tick,
  // Request
  input wire start,
  input wire write,
  input wire stretch,
  input wire [15:0] addr,
  input wire [7:0] wdata,
  output wire busy,
  output reg done_r,
  output reg [7:0] rdata_r,
  // Pins
  output reg [7:0] addr_high_lines_r,
  output reg [7:0] addr_data_low_out_r,
  output reg addr_data_low_oe_r,
  input wire [7:0] addr_data_low_in,
  output reg ale_r,
  output reg rd_n_r,
  output reg wr_n_r
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_LATCH = 3'h1;
  localparam [2:0] ST_HOLD = 3'h2;
  localparam [2:0] ST_STROBE = 3'h3;
  localparam [2:0] ST_TAIL = 3'h4;
  localparam [4:0] TAIL_N = 5'd`EXT_CYCLE_PERIODS - 5'd`ALE_PERIODS - 5'd`ADDR_HOLD_PERIODS - 5'd`STROBE_NORMAL;

  reg [2:0] state_r;
  reg [4:0] cnt_r;
  reg write_r;
  reg [4:0] strobe_len_r;
  reg [7:0] wdata_r;

  assign busy = (state_r != ST_IDLE);

  always @(posedge clock)
  begin
    done_r <= 1'b0;
    if (srst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h0;
      write_r <= 1'b0;
      strobe_len_r <= 5'h0;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
      addr_high_lines_r <= 8'h00;
      addr_data_low_out_r <= 8'h00;
      addr_data_low_oe_r <= 1'b0;
      ale_r <= 1'b0;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start)
          begin
            // High byte steady for the whole cycle
            addr_high_lines_r <= addr[15:8];
            addr_data_low_out_r <= addr[7:0];
            addr_data_low_oe_r <= 1'b1;
            ale_r <= 1'b1;
            write_r <= write;
            wdata_r <= wdata;
            strobe_len_r <= stretch ? 5'd`STROBE_STRETCH : 5'd`STROBE_NORMAL;
            cnt_r <= 5'd`ALE_PERIODS;
            state_r <= ST_LATCH;
          end
        end
        ST_LATCH:
        begin
          if (cpu_tick)
          begin
            cnt_r <= cnt_r - 5'd1;
            if (cnt_r == 5'd1)
            begin
              // Latch closes while the address still stands
              ale_r <= 1'b0;
              cnt_r <= 5'd`ADDR_HOLD_PERIODS;
              state_r <= ST_HOLD;
            end
          end
        end
        ST_HOLD:
        begin
          if (cpu_tick)
          begin
            cnt_r <= cnt_r - 5'd1;
            if (cnt_r == 5'd1)
            begin
              // Address leaves the lines as the strobe starts
              addr_data_low_out_r <= wdata_r;
              addr_data_low_oe_r <= write_r;
              rd_n_r <= write_r;
              wr_n_r <= ~write_r;
              cnt_r <= strobe_len_r;
              state_r <= ST_STROBE;
            end
          end
        end
        ST_STROBE:
        begin
          if (cpu_tick)
          begin
            cnt_r <= cnt_r - 5'd1;
            if (cnt_r == 5'd1)
            begin
              rdata_r <= write_r ? rdata_r : addr_data_low_in;
              rd_n_r <= 1'b1;
              wr_n_r <= 1'b1;
              cnt_r <= TAIL_N;
              state_r <= ST_TAIL;
            end
          end
        end
        ST_TAIL:
        begin
          // Write data held one period past the strobe
          if (cpu_tick)
          begin
            cnt_r <= cnt_r - 5'd1;
            if (cnt_r == 5'd1)
            begin
              addr_data_low_oe_r <= 1'b0;
              done_r <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// *** testbench/data_memory_access_properties.sv ***
// Purpose: Port-level properties of the data-memory access unit
// Assumes: Speed and stretch settings stay fixed while a bus cycle runs
// Notes: Bound to the design from the bench top
`timescale 1ns/1ns
`include "data_memory_map.vh"

module data_memory_access_properties
(
  // Clock and reset
  input wire clock,
  input wire srst,
  // Core side
  input wire double_speed_bit,
  input wire acc_req,
  input wire [1:0] acc_mode,
  input wire [7:0] acc_addr,
  input wire aux_control_inc,
  input wire acc_ack_r,
  input wire sfr_req,
  input wire [7:0] sfr_addr,
  input wire xmv_done_r,
  input wire [7:0] aux_config_reg_r,
  input wire [7:0] aux_control_reg_r,
  // Bus pins
  input wire addr_data_low_lines_oe,
  input wire ale,
  input wire rd_n,
  input wire wr_n
);
  reg [5:0] low_cnt_r;
  wire local_hit;
  assign local_hit = acc_addr == `ADDR_POINTER_LOW || acc_addr == `ADDR_POINTER_HIGH ||
    acc_addr == `ADDR_AUX_CONFIG || acc_addr == `ADDR_AUX_CONTROL;
  // Strobe-low run length, read at the release edge
  always @(posedge clock)
  begin
    if (srst || (rd_n && wr_n))
      low_cnt_r <= 6'h00;
    else
      low_cnt_r <= low_cnt_r + 6'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  ale_window_a: assert property (ale |-> addr_data_low_lines_oe && rd_n && wr_n)
    else $error("latch strobe overlaps a strobe or undriven lines");
  one_strobe_a: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes low together");
  read_release_a: assert property (!rd_n |-> !addr_data_low_lines_oe)
    else $error("lines driven during read strobe");
  strobe_width_a: assert property ($rose(rd_n && wr_n) |->
    low_cnt_r == (aux_config_reg_r[5] ? 6'h0F : 6'h03) * (double_speed_bit ? 6'h01 : 6'h02))
    else $error("strobe width wrong");
  bus_cycle_a: assert property ($rose(ale) && double_speed_bit && !aux_config_reg_r[5] |->
    !xmv_done_r [*4] ##[1:5] xmv_done_r)
    else $error("bus cycle length wrong");
  access_ack_a: assert property (acc_req |=> acc_ack_r)
    else $error("no acknowledge one cycle after request");
  reset_state_a: assert property ($fell(srst) |-> aux_config_reg_r == 8'h14 &&
    aux_control_reg_r == 8'h00 && rd_n && wr_n && !ale)
    else $error("wrong state after reset");
  inc_toggle_a: assert property (aux_control_inc |=> aux_control_reg_r[0] != $past(aux_control_reg_r[0]))
    else $error("increment did not flip pointer select");
  zero_bit_a: assert property (aux_control_reg_r[2] == 1'b0)
    else $error("aux control bit 2 set");
  sfr_route_a: assert property (acc_req && acc_mode == `MODE_DIRECT && acc_addr[7] && !local_hit |->
    sfr_req && sfr_addr == acc_addr)
    else $error("direct upper access not forwarded");
  indirect_local_a: assert property (acc_req && acc_mode == `MODE_INDIRECT |-> !sfr_req)
    else $error("indirect access forwarded");
endmodule

// *** testbench/ext_mem_model.sv ***
// Purpose: Far-side data memory on the multiplexed bus
// Assumes: Address captured on the falling latch strobe
// Notes: Undriven lines toggle each clock so stale data never passes
`timescale 1ns/1ns

module ext_mem_model
(
  // Clock
  input wire clock,
  // Bus pins
  input wire [7:0] addr_high_lines,
  input wire [7:0] addr_data_low_lines_out,
  input wire addr_data_low_lines_oe,
  input wire ale,
  input wire rd_n,
  input wire wr_n,
  output wire [7:0] addr_data_low_lines_in
);
  reg [7:0] mem [0:65535];
  reg [15:0] lat_r = 16'h0000;
  reg [7:0] idle_r = 8'h55;
  always @(posedge clock)
    idle_r <= ~idle_r;
  always @(negedge ale)
    lat_r <= {addr_high_lines, addr_data_low_lines_out};
  always @(posedge wr_n)
    mem[lat_r] = addr_data_low_lines_out;
  assign addr_data_low_lines_in = addr_data_low_lines_oe ? addr_data_low_lines_out :
    !rd_n ? mem[lat_r] : idle_r;
endmodule

// *** testbench/data_memory_access_tb_top.sv ***
// Purpose: Self-checking bench for the data-memory access unit
// Assumes: Inputs change on the falling clock edge
// Notes: Reference values come from bench arithmetic only
`timescale 1ns/1ns
`include "data_memory_map.vh"

module data_memory_access_tb_top;
  reg clock = 1'b0, srst = 1'b1, double_speed_bit = 1'b0, bank_select_low = 1'b0, bank_select_high = 1'b0;
  reg acc_req = 1'b0, acc_we = 1'b0, aux_control_inc = 1'b0, ptr_load = 1'b0, ptr_inc = 1'b0;
  reg [1:0] acc_mode = 2'h0;
  reg [7:0] acc_addr = 8'h00, acc_wdata = 8'h00, xmv_ri_addr = 8'h00, xmv_wdata = 8'h00, port_two_latch = 8'h00;
  reg [15:0] ptr_load_value = 16'h0000, rnd = 16'h000D;
  reg xmv_req = 1'b0, xmv_we = 1'b0, xmv_ri = 1'b0, stretch_m = 1'b0;
  wire cpu_tick_r, machine_tick_r, acc_ack_r, sfr_req, sfr_we, sfr_bit, xmv_busy, xmv_done_r;
  wire ale, rd_n, wr_n, addr_data_low_lines_oe;
  wire [7:0] acc_rdata_r, sfr_addr, sfr_wdata, xmv_rdata_r, aux_config_reg_r, aux_control_reg_r;
  wire [7:0] addr_high_lines, addr_data_low_lines_out, addr_data_low_lines_in, sfr_rdata;
  wire [2:0] sfr_bit_pos;
  wire [15:0] data_pointer;
  reg [7:0] rd_v;
  integer fail_count = 0, num_checks = 0, i, n, sz, ale_seen;
  assign sfr_rdata = sfr_addr ^ 8'h5A;
  always #20 clock = ~clock;
  data_memory_access i_data_memory_access (.clock(clock), .srst(srst), .double_speed_bit(double_speed_bit),
    .bank_select_low(bank_select_low), .bank_select_high(bank_select_high), .cpu_tick_r(cpu_tick_r),
    .machine_tick_r(machine_tick_r), .acc_req(acc_req), .acc_we(acc_we), .acc_mode(acc_mode),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .aux_control_inc(aux_control_inc), .acc_ack_r(acc_ack_r),
    .acc_rdata_r(acc_rdata_r), .sfr_req(sfr_req), .sfr_we(sfr_we), .sfr_bit(sfr_bit), .sfr_addr(sfr_addr),
    .sfr_bit_pos(sfr_bit_pos), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ptr_load(ptr_load),
    .ptr_load_value(ptr_load_value), .ptr_inc(ptr_inc), .data_pointer(data_pointer), .xmv_req(xmv_req),
    .xmv_we(xmv_we), .xmv_ri(xmv_ri), .xmv_ri_addr(xmv_ri_addr), .xmv_wdata(xmv_wdata),
    .port_two_latch(port_two_latch), .xmv_busy(xmv_busy), .xmv_done_r(xmv_done_r), .xmv_rdata_r(xmv_rdata_r),
    .aux_config_reg_r(aux_config_reg_r), .aux_control_reg_r(aux_control_reg_r),
    .addr_high_lines(addr_high_lines), .addr_data_low_lines_out(addr_data_low_lines_out),
    .addr_data_low_lines_oe(addr_data_low_lines_oe), .addr_data_low_lines_in(addr_data_low_lines_in),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
  ext_mem_model i_ext_mem_model (.clock(clock), .addr_high_lines(addr_high_lines),
    .addr_data_low_lines_out(addr_data_low_lines_out), .addr_data_low_lines_oe(addr_data_low_lines_oe),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .addr_data_low_lines_in(addr_data_low_lines_in));
  ////////////////////////////////////////////////////////////////////////////
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task check(input [23:0] got, input [23:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task acc(input we, input [1:0] md, input [7:0] ad, input [7:0] wd);
  begin
    {acc_req, acc_we, acc_mode, acc_addr, acc_wdata} = {1'b1, we, md, ad, wd};
    @(negedge clock);
    acc_req = 1'b0;
    check(acc_ack_r, 1'b1);
    rd_v = acc_rdata_r;
    @(negedge clock);
  end
  endtask
  // One-clock pulses on increment, load, pointer increment
  task pulse(input [2:0] s);
  begin
    {aux_control_inc, ptr_load, ptr_inc} = s;
    @(negedge clock);
    {aux_control_inc, ptr_load, ptr_inc} = 3'h0;
    @(negedge clock);
  end
  endtask
  task ptr(input [15:0] v);
  begin
    ptr_load_value = v;
    pulse(3'h2);
  end
  endtask
  // Bus moves must show the latch strobe and the full cycle length
  task xmv(input we, input ri, input [7:0] wd, input ext);
    integer lim;
  begin
    {xmv_req, xmv_we, xmv_ri, xmv_wdata} = {1'b1, we, ri, wd};
    ale_seen = 0;
    n = 0;
    @(negedge clock);
    xmv_req = 1'b0;
    check(xmv_busy, ext);
    while (xmv_done_r !== 1'b1 && n < 200)
    begin
      ale_seen = ale_seen | ale;
      n = n + 1;
      @(negedge clock);
    end
    rd_v = xmv_rdata_r;
    // Local span so the caller's size stays intact
    lim = (stretch_m ? 18 : 6) * (double_speed_bit ? 1 : 2);
    check(ale_seen, ext);
    check(ext ? (n >= lim && n <= lim + 3) : (n == 0), 1'b1);
    @(negedge clock);
  end
  endtask
  task gap;
  begin
    repeat (2)
    begin
      n = 0;
      @(negedge clock);
      while (machine_tick_r !== 1'b1 && n < 40)
      begin
        n = n + 1;
        @(negedge clock);
      end
    end
  end
  endtask
  task close_out;
  begin
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #2000000;
    fail_count = fail_count + 1;
    close_out;
  end
  initial
  begin
    repeat (5) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    check(aux_config_reg_r, 8'h14);
    check({rd_n, wr_n, ale, aux_control_reg_r, data_pointer[7:0]}, 19'h6_0000);
    for (i = 0; i < 4; i = i + 1)
    begin
      {bank_select_high, bank_select_low} = i[1:0];
      rnd = lfsr(rnd);
      acc(1'b1, `MODE_REGISTER, {5'h00, rnd[2:0]}, rnd[15:8]);
      acc(1'b0, `MODE_DIRECT, {3'h0, i[1:0], rnd[2:0]}, 8'h00);
      check(rd_v, rnd[15:8]);
      acc(1'b1, `MODE_DIRECT, {2'h1, rnd[5:0]}, rnd[7:0]);
      acc(1'b0, `MODE_INDIRECT, {2'h1, rnd[5:0]}, 8'h00);
      check(rd_v, rnd[7:0]);
      acc(1'b1, `MODE_DIRECT, {4'h2, rnd[6:3]}, 8'h00);
      acc(1'b1, `MODE_BIT, {1'b0, rnd[6:0]}, 8'h01);
      acc(1'b0, `MODE_DIRECT, {4'h2, rnd[6:3]}, 8'h00);
      check(rd_v, 8'h01 << rnd[2:0]);
      acc(1'b0, `MODE_BIT, {1'b0, rnd[6:0]}, 8'h00);
      check(rd_v[0], 1'b1);
    end
    acc(1'b1, `MODE_INDIRECT, 8'hC5, 8'h3C);
    acc(1'b1, `MODE_DIRECT, 8'hC5, 8'hA7);
    acc(1'b0, `MODE_INDIRECT, 8'hC5, 8'h00);
    check(rd_v, 8'h3C);
    acc(1'b0, `MODE_DIRECT, 8'h90, 8'h00);
    check(rd_v, 8'hCA);
    acc(1'b1, `MODE_DIRECT, `ADDR_POINTER_LOW, 8'h23);
    acc(1'b1, `MODE_DIRECT, `ADDR_POINTER_HIGH, 8'h01);
    pulse(3'h4);
    check({aux_control_reg_r[0], data_pointer}, 17'h1_0000);
    ptr(16'h0456);
    pulse(3'h1);
    check(data_pointer, 16'h0457);
    pulse(3'h4);
    check(data_pointer, 16'h0123);
    acc(1'b1, `MODE_DIRECT, `ADDR_AUX_CONTROL, 8'hFF);
    check({aux_control_reg_r, data_pointer}, 24'hFB_0457);
    pulse(3'h4);
    check(aux_control_reg_r, 8'hF8);
    for (i = 0; i < 8; i = i + 1)
    begin
      double_speed_bit = i[0];
      stretch_m = i[1];
      gap;
      check(n[15:0], double_speed_bit ? 16'h0005 : 16'h000B);
      acc(1'b1, `MODE_DIRECT, `ADDR_AUX_CONFIG, {2'h0, i[1], i[2:0], 2'h0});
      sz = (i < 4) ? 256 * (i + 1) : (i == 4) ? 1792 : 2048;
      rnd = lfsr(rnd);
      ptr(sz - 1);
      xmv(1'b1, 1'b0, rnd[7:0], 1'b0);
      xmv(1'b0, 1'b0, 8'h00, 1'b0);
      check(rd_v, rnd[7:0]);
      ptr(sz);
      xmv(1'b1, 1'b0, rnd[15:8], 1'b1);
      xmv(1'b0, 1'b0, 8'h00, 1'b1);
      check(rd_v, rnd[15:8]);
    end
    acc(1'b1, `MODE_DIRECT, `ADDR_AUX_CONFIG, 8'h16);
    stretch_m = 1'b0;
    port_two_latch = {5'h00, rnd[2:0]};
    xmv_ri_addr = rnd[15:8];
    xmv(1'b1, 1'b1, 8'h6B, 1'b1);
    ptr({5'h00, rnd[2:0], rnd[15:8]});
    xmv(1'b0, 1'b0, 8'h00, 1'b1);
    check(rd_v, 8'h6B);
    close_out;
  end
endmodule

bind data_memory_access data_memory_access_properties i_data_memory_access_properties (.clock(clock),
  .srst(srst), .double_speed_bit(double_speed_bit), .acc_req(acc_req), .acc_mode(acc_mode),
  .acc_addr(acc_addr), .aux_control_inc(aux_control_inc), .acc_ack_r(acc_ack_r), .sfr_req(sfr_req),
  .sfr_addr(sfr_addr), .xmv_done_r(xmv_done_r), .aux_config_reg_r(aux_config_reg_r),
  .aux_control_reg_r(aux_control_reg_r), .addr_data_low_lines_oe(addr_data_low_lines_oe), .ale(ale),
  .rd_n(rd_n), .wr_n(wr_n));
